/* File: hdl/mnr_pkg.sv */
// Package: constants, encodings and carriers of the role management port
package mnr_pkg;

  // Field widths of the subnetwork address and switch identifier
  localparam int MNR_SUBNET_W = 48;
  localparam int MNR_SWITCH_W = 8;

  // Clock rate and operation timeout
  localparam int MNR_CLK_HZ = 32'h017D_7840; // 25 MHz
  localparam int MNR_MS_PER_S = 32'h0000_03E8;
  localparam int MNR_TICK_CYCLES = MNR_CLK_HZ / MNR_MS_PER_S;
  localparam int MNR_OP_TIMEOUT_MS = 32'h0000_03E8;

  // Confirm result codes
  localparam logic [3:0] MNR_RES_DONE = 4'h0;
  localparam logic [3:0] MNR_RES_JOIN_REJECT = 4'h1;
  localparam logic [3:0] MNR_RES_JOIN_TIMEOUT = 4'h2;
  localparam logic [3:0] MNR_RES_LEAVE_TIMEOUT = 4'h2;
  localparam logic [3:0] MNR_RES_ROLE_TIMEOUT = 4'h1;
  localparam logic [3:0] MNR_RES_PROMOTE_REJECT = 4'h2;
  localparam logic [3:0] MNR_RES_SUBNET_OUT_OF_RANGE = 4'h8;
  localparam logic [3:0] MNR_RES_SWITCH_OUT_OF_RANGE = 4'h9;
  localparam logic [3:0] MNR_RES_REDUNDANT = 4'hA;

  // Reset values of the self-action enables
  localparam logic MNR_AUTO_JOIN_RST = 1'h1;
  localparam logic MNR_AUTO_PROMOTE_RST = 1'h1;

  typedef enum logic [1:0] {
    MNR_JOIN_NETWORK_OP = 2'h0,
    MNR_LEAVE_NETWORK_OP = 2'h1,
    MNR_RAISE_TO_SWITCH_OP = 2'h2,
    MNR_DROP_TO_TERMINAL_OP = 2'h3
  } mnr_op_t;

  // Target restriction of a join request; code 3 is illegal
  typedef enum logic [1:0] {
    MNR_JOIN_AUTO = 2'h0,
    MNR_JOIN_SUBNET = 2'h1,
    MNR_JOIN_SWITCH = 2'h2
  } mnr_join_mode_t;

  // Outcome reported by the protocol engine
  typedef enum logic [1:0] {
    MNR_ST_OK = 2'h0,
    MNR_ST_REJECT = 2'h1,
    MNR_ST_SUBNET_OUT_OF_RANGE = 2'h2,
    MNR_ST_SWITCH_OUT_OF_RANGE = 2'h3
  } mnr_status_t;

  // Functional role, Gray along disconnected, terminal, switch
  typedef enum logic [1:0] {
    MNR_ROLE_DISC = 2'h0,
    MNR_ROLE_TERM = 2'h1,
    MNR_ROLE_SWITCH = 2'h3
  } mnr_role_t;

  typedef struct packed {
    mnr_op_t op;
    mnr_join_mode_t mode;
    logic [MNR_SUBNET_W-1:0] subnetwork_address;
    logic [MNR_SWITCH_W-1:0] switch_identifier;
  } mnr_req_t;

  typedef struct packed {
    mnr_op_t op;
    logic [3:0] result;
    logic [MNR_SUBNET_W-1:0] subnetwork_address;
    logic [MNR_SWITCH_W-1:0] switch_identifier;
  } mnr_cnf_t;

  typedef struct packed {
    logic valid;
    mnr_op_t op;
    mnr_join_mode_t mode;
    logic [MNR_SUBNET_W-1:0] subnetwork_address;
    logic [MNR_SWITCH_W-1:0] switch_identifier;
    logic [MNR_SWITCH_W-1:0] proposed_address_field;
  } mnr_cmd_t;

  typedef struct packed {
    logic valid;
    mnr_status_t status;
    logic [MNR_SUBNET_W-1:0] subnetwork_address;
    logic [MNR_SWITCH_W-1:0] switch_identifier;
  } mnr_rsp_t;

  // Role events, used both for engine events and for indications
  typedef struct packed {
    logic joined;
    logic left;
    logic promoted;
    logic demoted;
    logic [MNR_SUBNET_W-1:0] subnetwork_address;
    logic [MNR_SWITCH_W-1:0] switch_identifier;
  } mnr_evt_t;

endpackage

/* File: hdl/mnr_timeout.sv */
// Operation timeout: millisecond tick divider and tick counter
`timescale 1ns/1ns
`default_nettype none
module mnr_timeout #(
  parameter int TICK_CYCLES = 25000,
  parameter int TIMEOUT_TICKS = 1000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic active,
  output logic expired
);

  logic [31:0] div_ff;
  logic [31:0] nxt_div;
  logic [31:0] ticks_ff;
  logic [31:0] nxt_ticks;
  logic expired_ff;
  logic nxt_expired;
  logic tick;

  // Divider and counter restart on start so every op gets a full budget
  always_comb begin
    tick = (div_ff == 32'(TICK_CYCLES - 1));
    nxt_div = tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
    nxt_ticks = ticks_ff;
    nxt_expired = 1'b0;
    if (start || !active) begin
      nxt_div = 32'h0000_0000;
      nxt_ticks = 32'h0000_0000;
    end else if (tick) begin
      nxt_ticks = ticks_ff + 32'h0000_0001;
      nxt_expired = (ticks_ff == 32'(TIMEOUT_TICKS - 1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 32'h0000_0000;
      ticks_ff <= 32'h0000_0000;
      expired_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      ticks_ff <= nxt_ticks;
      expired_ff <= nxt_expired;
    end
  end

  assign expired = expired_ff;

endmodule // mnr_timeout
`default_nettype wire

/* File: hdl/mnr_role_mgr.sv */
// Management port for join, leave, promote and demote of a service node
`timescale 1ns/1ns
`default_nettype none
module mnr_role_mgr
  import mnr_pkg::*;
#(
  parameter bit IS_BASE = 1'b0,
  parameter int TICK_CYCLES = MNR_TICK_CYCLES,
  parameter int TIMEOUT_MS = MNR_OP_TIMEOUT_MS,
  parameter logic [MNR_SWITCH_W-1:0] PROPOSED_ADDR = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire mnr_req_t req,
  output logic req_ready,
  output logic cnf_valid,
  output mnr_cnf_t cnf,
  output mnr_cmd_t cmd,
  input wire mnr_rsp_t rsp,
  input wire mnr_evt_t evt,
  output mnr_evt_t ind,
  output mnr_role_t role,
  output logic auto_join_en,
  output logic auto_promote_en
);

  typedef enum logic {
    MNR_ST_IDLE = 1'b0,
    MNR_ST_WAIT = 1'b1
  } mnr_state_t;

  // Engine outcome to the op's own result code
  function automatic logic [3:0] mnr_map_result(mnr_op_t op,
                                                mnr_status_t st);
    logic [3:0] code;
    code = MNR_RES_DONE;
    unique case (st)
      MNR_ST_OK: code = MNR_RES_DONE;
      MNR_ST_REJECT: code = (op == MNR_RAISE_TO_SWITCH_OP) ?
                            MNR_RES_PROMOTE_REJECT : MNR_RES_JOIN_REJECT;
      MNR_ST_SUBNET_OUT_OF_RANGE: code = MNR_RES_SUBNET_OUT_OF_RANGE;
      MNR_ST_SWITCH_OUT_OF_RANGE: code = MNR_RES_SWITCH_OUT_OF_RANGE;
    endcase
    return code;
  endfunction

  // Timeout code differs between the address ops and the role ops
  function automatic logic [3:0] mnr_timeout_result(mnr_op_t op);
    return (op == MNR_JOIN_NETWORK_OP) ? MNR_RES_JOIN_TIMEOUT :
           (op == MNR_LEAVE_NETWORK_OP) ? MNR_RES_LEAVE_TIMEOUT :
           MNR_RES_ROLE_TIMEOUT;
  endfunction

  mnr_state_t state_ff;
  mnr_state_t nxt_state;
  mnr_req_t pend_ff;
  mnr_req_t nxt_pend;
  logic ready_ff;
  logic nxt_ready;
  logic cnf_valid_ff;
  logic nxt_cnf_valid;
  mnr_cnf_t cnf_ff;
  mnr_cnf_t nxt_cnf;
  mnr_cmd_t cmd_ff;
  mnr_cmd_t nxt_cmd;
  mnr_role_t role_ff;
  mnr_role_t nxt_role;
  mnr_evt_t ind_ff;
  mnr_evt_t nxt_ind;
  logic [MNR_SUBNET_W-1:0] subnet_ff;
  logic [MNR_SUBNET_W-1:0] nxt_subnet;
  logic [MNR_SWITCH_W-1:0] switch_ff;
  logic [MNR_SWITCH_W-1:0] nxt_switch;
  logic auto_join_ff;
  logic nxt_auto_join;
  logic auto_promote_ff;
  logic nxt_auto_promote;
  logic accept, refused, redundant, launch, expired, rsp_ok;
  mnr_status_t rsp_st;

  assign accept = req_valid && ready_ff;
  // Base node does not export join and leave
  assign refused = IS_BASE && (req.op == MNR_JOIN_NETWORK_OP ||
                               req.op == MNR_LEAVE_NETWORK_OP);
  // Requests that need no engine work answer at once
  always_comb begin
    redundant = 1'b0;
    unique case (req.op)
      MNR_JOIN_NETWORK_OP: redundant = 1'b0;
      MNR_LEAVE_NETWORK_OP: redundant = (role_ff == MNR_ROLE_DISC);
      MNR_RAISE_TO_SWITCH_OP:
        redundant = (role_ff == MNR_ROLE_SWITCH);
      MNR_DROP_TO_TERMINAL_OP:
        redundant = (role_ff != MNR_ROLE_SWITCH);
    endcase
  end
  assign launch = accept && !refused && !redundant;

  // An engine success that ignored the join restriction is reported
  // as out of range rather than silently accepted
  always_comb begin
    rsp_st = rsp.status;
    if (pend_ff.op == MNR_JOIN_NETWORK_OP && rsp.status == MNR_ST_OK) begin
      if (pend_ff.mode == MNR_JOIN_SUBNET &&
          rsp.subnetwork_address != pend_ff.subnetwork_address) begin
        rsp_st = MNR_ST_SUBNET_OUT_OF_RANGE;
      end else if (pend_ff.mode == MNR_JOIN_SWITCH &&
                   rsp.switch_identifier != pend_ff.switch_identifier) begin
        rsp_st = MNR_ST_SWITCH_OUT_OF_RANGE;
      end
    end
    rsp_ok = (state_ff == MNR_ST_WAIT) && rsp.valid && rsp_st == MNR_ST_OK;
  end

  mnr_timeout #(
    .TICK_CYCLES(TICK_CYCLES),
    .TIMEOUT_TICKS(TIMEOUT_MS)
  ) u_timeout (
    .clk(clk),
    .rst_n(rst_n),
    .start(launch),
    .active(state_ff == MNR_ST_WAIT),
    .expired(expired)
  );

  // Request sequencing, engine command and confirm
  always_comb begin
    nxt_state = state_ff;
    nxt_pend = pend_ff;
    nxt_cnf_valid = 1'b0;
    nxt_cnf = cnf_ff;
    nxt_cmd = cmd_ff;
    nxt_cmd.valid = 1'b0;
    unique case (state_ff)
      MNR_ST_IDLE: begin
        if (accept && !refused && redundant) begin
          nxt_cnf_valid = 1'b1;
          nxt_cnf = '{op: req.op, result: MNR_RES_REDUNDANT,
                      subnetwork_address: '0, switch_identifier: '0};
        end else if (launch) begin
          nxt_state = MNR_ST_WAIT;
          nxt_pend = req;
          nxt_cmd.valid = 1'b1;
          nxt_cmd.op = req.op;
          nxt_cmd.mode = (req.mode == MNR_JOIN_SUBNET ||
            req.mode == MNR_JOIN_SWITCH) ? req.mode : MNR_JOIN_AUTO;
          nxt_cmd.subnetwork_address = req.subnetwork_address;
          nxt_cmd.switch_identifier = req.switch_identifier;
          nxt_cmd.proposed_address_field = PROPOSED_ADDR;
        end
      end
      MNR_ST_WAIT: begin
        // A response in the expiry cycle still wins
        if (rsp.valid || expired) begin
          nxt_state = MNR_ST_IDLE;
          nxt_cnf_valid = 1'b1;
          nxt_cnf.op = pend_ff.op;
          nxt_cnf.subnetwork_address = '0;
          nxt_cnf.switch_identifier = '0;
          if (rsp.valid) begin
            nxt_cnf.result = mnr_map_result(pend_ff.op, rsp_st);
            if (pend_ff.op == MNR_JOIN_NETWORK_OP) begin
              nxt_cnf.subnetwork_address = rsp.subnetwork_address;
              nxt_cnf.switch_identifier = rsp.switch_identifier;
            end
          end else begin
            nxt_cnf.result = mnr_timeout_result(pend_ff.op);
          end
        end
      end
    endcase
    nxt_ready = (nxt_state == MNR_ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= MNR_ST_IDLE;
      pend_ff <= '0;
      ready_ff <= 1'b0;
      cnf_valid_ff <= 1'b0;
      cnf_ff <= '0;
      cmd_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      ready_ff <= nxt_ready;
      cnf_valid_ff <= nxt_cnf_valid;
      cnf_ff <= nxt_cnf;
      cmd_ff <= nxt_cmd;
    end
  end

  // Role tracking; a confirmed success overrides an engine event
  always_comb begin
    nxt_role = role_ff;
    nxt_subnet = subnet_ff;
    nxt_switch = switch_ff;
    if (evt.left) begin
      nxt_role = MNR_ROLE_DISC;
    end else if (evt.promoted) begin
      nxt_role = MNR_ROLE_SWITCH;
    end else if (evt.demoted) begin
      nxt_role = MNR_ROLE_TERM;
    end else if (evt.joined) begin
      nxt_role = MNR_ROLE_TERM;
      nxt_subnet = evt.subnetwork_address;
      nxt_switch = evt.switch_identifier;
    end
    if (rsp_ok) begin
      unique case (pend_ff.op)
        MNR_JOIN_NETWORK_OP: begin
          nxt_role = MNR_ROLE_TERM;
          nxt_subnet = rsp.subnetwork_address;
          nxt_switch = rsp.switch_identifier;
        end
        MNR_LEAVE_NETWORK_OP: nxt_role = MNR_ROLE_DISC;
        MNR_RAISE_TO_SWITCH_OP: nxt_role = MNR_ROLE_SWITCH;
        MNR_DROP_TO_TERMINAL_OP: nxt_role = MNR_ROLE_TERM;
      endcase
    end
    // Indications follow role edges, whoever caused them
    nxt_ind.joined = (role_ff == MNR_ROLE_DISC) &&
                     (nxt_role != MNR_ROLE_DISC);
    nxt_ind.left = (role_ff != MNR_ROLE_DISC) &&
                   (nxt_role == MNR_ROLE_DISC);
    nxt_ind.promoted = (role_ff != MNR_ROLE_SWITCH) &&
                       (nxt_role == MNR_ROLE_SWITCH);
    nxt_ind.demoted = (role_ff == MNR_ROLE_SWITCH) &&
                      (nxt_role == MNR_ROLE_TERM);
    nxt_ind.subnetwork_address = nxt_subnet;
    nxt_ind.switch_identifier = nxt_switch;
  end

  // Self-action enables; the engine must obey them
  always_comb begin
    nxt_auto_join = auto_join_ff;
    nxt_auto_promote = auto_promote_ff;
    if (accept && !refused && req.op == MNR_JOIN_NETWORK_OP) begin
      nxt_auto_join = 1'b1;
    end
    if (nxt_cnf_valid && nxt_cnf.op == MNR_LEAVE_NETWORK_OP) begin
      nxt_auto_join = 1'b0;
    end
    if (accept && req.op == MNR_RAISE_TO_SWITCH_OP) begin
      nxt_auto_promote = 1'b1;
    end
    if (accept && req.op == MNR_DROP_TO_TERMINAL_OP) begin
      nxt_auto_promote = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      role_ff <= MNR_ROLE_DISC;
      subnet_ff <= '0;
      switch_ff <= '0;
      ind_ff <= '0;
      auto_join_ff <= MNR_AUTO_JOIN_RST;
      auto_promote_ff <= MNR_AUTO_PROMOTE_RST;
    end else begin
      role_ff <= nxt_role;
      subnet_ff <= nxt_subnet;
      switch_ff <= nxt_switch;
      ind_ff <= nxt_ind;
      auto_join_ff <= nxt_auto_join;
      auto_promote_ff <= nxt_auto_promote;
    end
  end

  assign req_ready = ready_ff;
  assign cnf_valid = cnf_valid_ff;
  assign cnf = cnf_ff;
  assign cmd = cmd_ff;
  assign ind = ind_ff;
  assign role = role_ff;
  assign auto_join_en = auto_join_ff;
  assign auto_promote_en = auto_promote_ff;

  // Checks on the confirm and role behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_join_cmd_mode: assert property (
    launch && req.op == MNR_JOIN_NETWORK_OP && req.mode == MNR_JOIN_SUBNET
    |=> cmd.valid && cmd.mode == MNR_JOIN_SUBNET &&
        cmd.subnetwork_address == $past(req.subnetwork_address))
    else $error("join command lost its subnet restriction");
  a_base_no_join: assert property (
    cmd.valid |-> !(IS_BASE && (cmd.op == MNR_JOIN_NETWORK_OP ||
                               cmd.op == MNR_LEAVE_NETWORK_OP)))
    else $error("base node issued a join or leave");
  a_join_timeout_code: assert property (
    state_ff == MNR_ST_WAIT && expired && !rsp.valid &&
    pend_ff.op == MNR_JOIN_NETWORK_OP
    |=> cnf_valid && cnf.result == 4'h2)
    else $error("join timeout code wrong");
  a_switch_mismatch: assert property (
    state_ff == MNR_ST_WAIT && rsp.valid && rsp.status == MNR_ST_OK &&
    pend_ff.op == MNR_JOIN_NETWORK_OP && pend_ff.mode == MNR_JOIN_SWITCH &&
    rsp.switch_identifier != pend_ff.switch_identifier
    |=> cnf_valid && cnf.result == 4'h9 && role == $past(role))
    else $error("join through wrong switch accepted");
  a_leave_redundant: assert property (
    accept && !refused && req.op == MNR_LEAVE_NETWORK_OP &&
    role_ff == MNR_ROLE_DISC
    |=> cnf_valid && cnf.result == 4'hA && !cmd.valid)
    else $error("redundant leave not answered with 10");
  a_no_self_rejoin: assert property (
    cnf_valid && cnf.op == MNR_LEAVE_NETWORK_OP |-> !auto_join_en)
    else $error("self join still enabled after leave confirm");
  a_join_ind: assert property (
    $rose(role != MNR_ROLE_DISC) |-> ind.joined &&
      ind.subnetwork_address == subnet_ff)
    else $error("registration indication missing");
  a_leave_ind: assert property (
    $fell(role != MNR_ROLE_DISC) |-> ind.left)
    else $error("unregistration indication missing");
  a_promote_code: assert property (
    state_ff == MNR_ST_WAIT && expired && !rsp.valid &&
    pend_ff.op == MNR_RAISE_TO_SWITCH_OP |=> cnf.result == 4'h1)
    else $error("promote timeout code wrong");
  a_promote_ind: assert property (
    $rose(role == MNR_ROLE_SWITCH) |-> ind.promoted)
    else $error("promotion indication missing");
  a_demote_redundant: assert property (
    accept && req.op == MNR_DROP_TO_TERMINAL_OP && role_ff == MNR_ROLE_TERM
    |=> cnf_valid && cnf.result == 4'hA)
    else $error("redundant demote not answered with 10");
  a_no_self_promote: assert property (
    accept && req.op == MNR_DROP_TO_TERMINAL_OP |=> !auto_promote_en [*2])
    else $error("self promotion left enabled after demote");
  a_one_confirm: assert property (
    cnf_valid |=> !cnf_valid || $past(ready_ff))
    else $error("second confirm without a new request");

  c_join_done: cover property (cnf_valid && cnf.op == MNR_JOIN_NETWORK_OP &&
                               cnf.result == 4'h0);
  c_leave_redundant: cover property (cnf_valid && cnf.result == 4'hA &&
                                     cnf.op == MNR_LEAVE_NETWORK_OP);
  c_promote_timeout: cover property (cnf_valid && cnf.result == 4'h1 &&
                                     cnf.op == MNR_RAISE_TO_SWITCH_OP);
  c_demote_done: cover property (ind.demoted);

endmodule // mnr_role_mgr
`default_nettype wire

/* File: verification/mnr_engine_model.sv */
// Protocol engine stand-in that answers role commands after a set delay
`timescale 1ns/1ns
`default_nettype none
module mnr_engine_model
  import mnr_pkg::*;
#(
  parameter logic [MNR_SUBNET_W-1:0] OWN_SUBNET = 48'h0000_00AB_CDEF,
  parameter logic [MNR_SWITCH_W-1:0] OWN_SWITCH = 8'h5A
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire mnr_cmd_t cmd,
  input wire mnr_status_t st_sel,
  input wire logic [7:0] dly,
  input wire logic mute,
  input wire logic stray,
  output var mnr_rsp_t rsp
);
  mnr_cmd_t held;
  logic busy;
  logic [7:0] cnt;

  // Idle fields toggle each cycle so a stale answer is never trusted
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
      busy <= 1'b0;
      cnt <= 8'h00;
      rsp <= '0;
    end else begin
      rsp <= ~rsp;
      rsp.valid <= 1'b0;
      if (cmd.valid) begin
        held <= cmd;
        busy <= ~mute; // Muted engine forces a timeout
        cnt <= 8'h00;
      end else if (busy && cnt >= dly) begin
        busy <= 1'b0;
        rsp.valid <= 1'b1;
        rsp.status <= st_sel;
        // A stray engine ignores the join restriction
        rsp.subnetwork_address <= (held.mode == MNR_JOIN_SUBNET && !stray) ?
          held.subnetwork_address : OWN_SUBNET;
        rsp.switch_identifier <= (held.mode == MNR_JOIN_SWITCH && !stray) ?
          held.switch_identifier : OWN_SWITCH;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule // mnr_engine_model
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the role management port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module testbench
  import mnr_pkg::*;
;
  localparam int TICKS = 4;
  localparam int TMO_MS = 3;
  localparam logic [MNR_SWITCH_W-1:0] PADDR = 8'h3C;
  localparam logic [MNR_SUBNET_W-1:0] ENG_SUB = 48'h0000_00AB_CDEF;
  localparam logic [MNR_SWITCH_W-1:0] ENG_SW = 8'h5A;
  localparam logic [MNR_SUBNET_W-1:0] SUB_A = 48'h0000_1357_9BDF;
  localparam logic [MNR_SWITCH_W-1:0] SW_A = 8'h21;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_valid_b = 1'b0;
  mnr_req_t req = '0;
  mnr_evt_t evt = '0;
  mnr_status_t st_sel = MNR_ST_OK;
  logic [7:0] dly = 8'h02;
  logic mute = 1'b0;
  logic stray = 1'b0;
  logic req_ready, cnf_valid, auto_join_en, auto_promote_en, rdy_b, cnfv_b;
  mnr_cnf_t cnf, got;
  mnr_cmd_t cmd, cmd_b, last_cmd;
  mnr_rsp_t rsp;
  mnr_evt_t ind, got_ind;
  mnr_role_t role, got_role;
  int n_fail = 0;
  int tests_run = 0;
  int n_cnf = 0;
  int n_cnf_b = 0;

  always #20 clk = ~clk;

  // Short timeout counts keep the run brief
  mnr_role_mgr #(.TICK_CYCLES(TICKS), .TIMEOUT_MS(TMO_MS),
    .PROPOSED_ADDR(PADDR)) dut (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .cnf_valid(cnf_valid), .cnf(cnf), .cmd(cmd), .rsp(rsp), .evt(evt),
    .ind(ind), .role(role), .auto_join_en(auto_join_en),
    .auto_promote_en(auto_promote_en));
  // Base node copy, only offered join and leave
  mnr_role_mgr #(.IS_BASE(1'b1), .TICK_CYCLES(TICKS), .TIMEOUT_MS(TMO_MS))
    dut_base (.clk(clk), .rst_n(rst_n), .req_valid(req_valid_b),
    .req(req), .req_ready(rdy_b), .cnf_valid(cnfv_b), .cnf(), .cmd(cmd_b),
    .rsp('0), .evt('0), .ind(), .role(), .auto_join_en(),
    .auto_promote_en());
  mnr_engine_model #(.OWN_SUBNET(ENG_SUB), .OWN_SWITCH(ENG_SW)) engine (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .st_sel(st_sel), .dly(dly),
    .mute(mute), .stray(stray), .rsp(rsp));

  // Count confirm pulses and keep the last engine command
  always @(posedge clk) begin
    if (cnf_valid === 1'b1) n_cnf++;
    if (cnfv_b === 1'b1 || cmd_b.valid === 1'b1) n_cnf_b++;
    if (cmd.valid === 1'b1) last_cmd <= cmd;
  end

  // Wait up to 40 cycles for ready, then offer one request for one cycle
  task automatic send(input mnr_op_t op, input mnr_join_mode_t md);
    int i;
    req = '{op: op, mode: md, subnetwork_address: SUB_A,
      switch_identifier: SW_A};
    for (i = 0; i < 40 && req_ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask

  // Request, catch its one-cycle confirm, judge result and count
  task automatic req_cnf(input mnr_op_t op, input mnr_join_mode_t md,
      input mnr_status_t st, input logic [3:0] exp);
    int c0;
    int i;
    st_sel = st;
    c0 = n_cnf;
    send(op, md);
    for (i = 0; i < 60 && cnf_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    got = cnf;
    got_ind = ind;
    got_role = role;
    repeat (3) @(posedge clk);
    #1;
    `CHK(got.result, exp)
    `CHK(got.op, op)
    `CHK(n_cnf - c0, 1)
  endtask

  task automatic t_redundant();
    req_cnf(MNR_LEAVE_NETWORK_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_REDUNDANT);
    `CHK(auto_join_en, 1'b0)
    req_cnf(MNR_DROP_TO_TERMINAL_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_REDUNDANT);
    `CHK(auto_promote_en, 1'b0)
    $display("test redundant done");
  endtask

  task automatic t_join();
    mnr_join_mode_t md [4] = '{MNR_JOIN_AUTO, MNR_JOIN_SUBNET,
      MNR_JOIN_SWITCH, MNR_JOIN_AUTO};
    mnr_status_t st [4] = '{MNR_ST_REJECT, MNR_ST_SUBNET_OUT_OF_RANGE,
      MNR_ST_SWITCH_OUT_OF_RANGE, MNR_ST_OK};
    logic [3:0] ex [4] = '{MNR_RES_JOIN_REJECT, MNR_RES_SUBNET_OUT_OF_RANGE,
      MNR_RES_SWITCH_OUT_OF_RANGE, MNR_RES_JOIN_TIMEOUT};
    // Last entry has a silent engine
    for (int k = 0; k < 4; k++) begin
      mute = (k == 3);
      req_cnf(MNR_JOIN_NETWORK_OP, md[k], st[k], ex[k]);
      `CHK(last_cmd.mode, md[k])
      `CHK(last_cmd.subnetwork_address, SUB_A)
      `CHK(last_cmd.switch_identifier, SW_A)
      `CHK(got_role, MNR_ROLE_DISC)
    end
    mute = 1'b0;
    // Engine success outside the restriction must not count as a join
    stray = 1'b1;
    req_cnf(MNR_JOIN_NETWORK_OP, MNR_JOIN_SUBNET, MNR_ST_OK,
      MNR_RES_SUBNET_OUT_OF_RANGE);
    req_cnf(MNR_JOIN_NETWORK_OP, MNR_JOIN_SWITCH, MNR_ST_OK,
      MNR_RES_SWITCH_OUT_OF_RANGE);
    `CHK(got_role, MNR_ROLE_DISC)
    stray = 1'b0;
    req_cnf(MNR_JOIN_NETWORK_OP, MNR_JOIN_SUBNET, MNR_ST_OK,
      MNR_RES_DONE);
    `CHK(got.subnetwork_address, SUB_A)
    `CHK(got.switch_identifier, ENG_SW)
    `CHK(got_ind.joined, 1'b1)
    `CHK(got_ind.subnetwork_address, SUB_A)
    `CHK(got_role, MNR_ROLE_TERM)
    $display("test join done");
  endtask

  task automatic t_promote();
    req_cnf(MNR_RAISE_TO_SWITCH_OP, MNR_JOIN_AUTO, MNR_ST_REJECT,
      MNR_RES_PROMOTE_REJECT);
    mute = 1'b1;
    req_cnf(MNR_RAISE_TO_SWITCH_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_ROLE_TIMEOUT);
    mute = 1'b0;
    dly = 8'h09;
    req_cnf(MNR_RAISE_TO_SWITCH_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_DONE);
    dly = 8'h02;
    `CHK(last_cmd.op, MNR_RAISE_TO_SWITCH_OP)
    `CHK(last_cmd.proposed_address_field, PADDR)
    `CHK(got_role, MNR_ROLE_SWITCH)
    `CHK(got_ind.promoted, 1'b1)
    req_cnf(MNR_RAISE_TO_SWITCH_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_REDUNDANT);
    $display("test promote done");
  endtask

  task automatic t_demote();
    mute = 1'b1;
    req_cnf(MNR_DROP_TO_TERMINAL_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_ROLE_TIMEOUT);
    mute = 1'b0;
    req_cnf(MNR_DROP_TO_TERMINAL_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_DONE);
    `CHK(got_ind.demoted, 1'b1)
    `CHK(got_role, MNR_ROLE_TERM)
    `CHK(auto_promote_en, 1'b0)
    req_cnf(MNR_DROP_TO_TERMINAL_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_REDUNDANT);
    $display("test demote done");
  endtask

  task automatic t_leave();
    mute = 1'b1;
    req_cnf(MNR_LEAVE_NETWORK_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_LEAVE_TIMEOUT);
    mute = 1'b0;
    req_cnf(MNR_LEAVE_NETWORK_OP, MNR_JOIN_AUTO, MNR_ST_OK,
      MNR_RES_DONE);
    `CHK(got_ind.left, 1'b1)
    `CHK(got_role, MNR_ROLE_DISC)
    `CHK(auto_join_en, 1'b0)
    repeat (20) @(posedge clk);
    #1;
    `CHK(role, MNR_ROLE_DISC)
    $display("test leave done");
  endtask

  // Engine-initiated role changes surface as indications; returns while
  // the one-cycle indication still stands
  task automatic evt_pulse(input mnr_evt_t e);
    @(posedge clk);
    #1;
    evt = e;
    @(posedge clk);
    #1;
    evt = '0;
  endtask

  task automatic t_events();
    mnr_evt_t e;
    e = '0;
    e.joined = 1'b1;
    e.subnetwork_address = ENG_SUB;
    e.switch_identifier = ENG_SW;
    evt_pulse(e);
    `CHK(ind.joined, 1'b1)
    `CHK(ind.switch_identifier, ENG_SW)
    `CHK(role, MNR_ROLE_TERM)
    e = '0;
    e.left = 1'b1;
    evt_pulse(e);
    `CHK(ind.left, 1'b1)
    `CHK(role, MNR_ROLE_DISC)
    $display("test events done");
  endtask

  task automatic t_base();
    int c0;
    c0 = n_cnf_b;
    for (int k = 0; k < 2; k++) begin
      req.op = k ? MNR_LEAVE_NETWORK_OP : MNR_JOIN_NETWORK_OP;
      req_valid_b = 1'b1;
      @(posedge clk);
      #1;
      req_valid_b = 1'b0;
      repeat (30) @(posedge clk);
      #1;
      `CHK(rdy_b, 1'b1)
    end
    `CHK(n_cnf_b - c0, 0)
    $display("test base done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence; reset held five cycles
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    `CHK(role, MNR_ROLE_DISC)
    `CHK(auto_join_en, 1'b1)
    `CHK(req_ready, 1'b1)
    $display("test reset done");
    t_redundant();
    t_join();
    t_promote();
    t_demote();
    t_leave();
    t_events();
    t_base();
    final_report();
  end

  // Watchdog well beyond the roughly 300 cycles the tests need
  initial begin
    #(40 * 5000);
    n_fail++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
